/* File: rtl/cbc_regs.svh */
// constants of the can bridge configuration command interpreter
`ifndef CBC_REGS_SVH
`define CBC_REGS_SVH

// request and response identifiers
`define CBC_RSP_OFS      11'h400
`define CBC_CMD_FWVER    11'h001
`define CBC_CMD_MRESET   11'h002
`define CBC_CMD_SETTMO   11'h003
`define CBC_CMD_GETTMO   11'h004
`define CBC_CMD_SETLSN   11'h005
`define CBC_CMD_GETLSN   11'h006
`define CBC_CH1_GRP      3'h1
`define CBC_CH2_GRP      3'h2
`define CBC_SUB_START    8'h01
`define CBC_SUB_STOP     8'h02
`define CBC_SUB_ALLPASS  8'h04
`define CBC_SUB_S11      8'h11
`define CBC_SUB_G29      8'h14

// result codes
`define CBC_RC_OK        8'h00
`define CBC_RC_PROC      8'h01
`define CBC_RC_PARAM     8'h02
`define CBC_RC_FILT      8'h03
`define CBC_RC_CMD       8'h04
`define CBC_RC_CHAN      8'h05
`define CBC_RC_LEN       8'h06
`define CBC_RC_RTR       8'h07

// request format
`define CBC_REQ_DLC      4'h8
`define CBC_UNUSED_WORD  32'hffffffff

// firmware version bytes, value arbitrary
`define CBC_FW_INT       8'h01
`define CBC_FW_FRAC      8'h00

// wishbone register offsets and fields
`define CBC_OFS_STAT     4'h0
`define CBC_OFS_MASK     4'h4
`define CBC_OFS_CTRL     4'h8
`define CBC_OFS_INFO     4'hc
`define CBC_ST_DONE      0
`define CBC_ST_MRST      1
`define CBC_ST_ARST      2
`define CBC_ST_ERR       3
`define CBC_CTRL_RST     1'b1

// filter table depth per channel
`define CBC_FLT_DEPTH    16

// timing: clock rate and the one second tick of the bus-off timer
`define CBC_CLK_HZ       25000000
`define CBC_TICK_S       1

`endif

/* File: rtl/cbc_pkg.sv */
// types of the can bridge configuration command interpreter
package cbc_pkg;
    typedef enum logic [1:0] {FT_S11, FT_G11, FT_S29, FT_G29} cbc_ftype_t;
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_WRHI, ST_RESP} cbc_state_t;
endpackage

/* File: rtl/cbc_filter.sv */
// white-list id filter table of one channel
`timescale 1ns/1ps
`include "cbc_regs.svh"
module cbc_filter
    import cbc_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // table programming
    input  wire logic        clear_i,
    input  wire logic        wr_i,
    input  cbc_ftype_t       wr_type_i,
    input  wire logic [28:0] wr_lo_i,
    input  wire logic [28:0] wr_hi_i,
    output logic             full_o,
    // identifier check
    input  wire logic        chk_i,
    input  wire logic [28:0] chk_id_i,
    input  wire logic        chk_ext_i,
    output logic             match_o,
    output logic             match_vld_o
);
    cbc_ftype_t  type_mem [`CBC_FLT_DEPTH];
    logic [28:0] lo_mem   [`CBC_FLT_DEPTH];
    logic [28:0] hi_mem   [`CBC_FLT_DEPTH];
    logic [4:0]  cnt_ff;
    logic        hit;

    assign full_o = (cnt_ff == 5'(`CBC_FLT_DEPTH));

    // entry store; an empty table is the all-pass state
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            cnt_ff <= 5'h00;
        end else if (wr_i && !full_o) begin
            type_mem[cnt_ff[3:0]] <= wr_type_i;
            lo_mem[cnt_ff[3:0]]   <= wr_lo_i;
            hi_mem[cnt_ff[3:0]]   <= wr_hi_i;
            cnt_ff                <= cnt_ff + 5'h01;
        end
    end

    // parallel compare against every stored entry
    always_comb begin
        hit = (cnt_ff == 5'h00);
        for (int i = 0; i < `CBC_FLT_DEPTH; i++) begin
            if (5'(i) < cnt_ff && (chk_ext_i == type_mem[i][1])) begin
                if (type_mem[i][0]) begin
                    if (chk_id_i >= lo_mem[i] && chk_id_i <= hi_mem[i]) hit = 1'b1;
                end else if (chk_id_i == lo_mem[i]) begin
                    hit = 1'b1;
                end
            end
        end
    end

    // registered verdict
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_o     <= 1'b0;
            match_vld_o <= 1'b0;
        end else begin
            match_o     <= chk_i & hit;
            match_vld_o <= chk_i;
        end
    end

    property p_empty_pass;
        @(posedge clk_i) disable iff (rst_i)
        (chk_i && cnt_ff == 5'h00) |=> (match_o && match_vld_o);
    endproperty
    a_empty_pass: assert property (p_empty_pass) else $error("empty table blocked an id");
    c_filter_hit: cover property (@(posedge clk_i) disable iff (rst_i)
        chk_i && cnt_ff != 5'h00 && hit);
endmodule // cbc_filter

/* File: rtl/cbc_top.sv */
// configuration command interpreter of a two-channel can bridge
`timescale 1ns/1ps
`include "cbc_regs.svh"
// Functional notes
// - response id is request id plus 0x400
// - version reply: fraction byte, then integer byte
// - module reset answers result code only
// - 0x003 stores time, answers one byte
// - 0x004 returns stored time, low first
// - nonzero time resets after persistent bus-off
// - per-channel listen-only, no ack, readable
// - words of all ones are ignored, except one alone in a group entry (result 0x02)
// - filter entries form the accept white list
// - empty table passes every identifier
// - module reset only in configuration mode
// - result codes 0x00 to 0x07
module cbc_top
    import cbc_pkg::*;
#(
    parameter int TICK_CYC = `CBC_CLK_HZ * `CBC_TICK_S
)(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    output logic             irq_o,
    // request frame from the can controller
    input  wire logic        req_valid_i,
    input  wire logic [10:0] req_id_i,
    input  wire logic [3:0]  req_dlc_i,
    input  wire logic        req_rtr_i,
    input  wire logic [63:0] req_data_i,
    output logic             req_ready_o,
    // response frame to the can controller
    output logic             resp_valid_o,
    output logic [10:0]      resp_id_o,
    output logic [3:0]       resp_dlc_o,
    output logic [63:0]      resp_data_o,
    input  wire logic        resp_ready_i,
    // mode strap pin and channel status from the controllers
    input  wire logic        cfg_mode_i,
    input  wire logic [1:0]  bus_off_i,
    // received identifiers to screen
    input  wire logic [1:0]  rx_vld_i,
    input  wire logic [1:0]  rx_ext_i,
    input  wire logic [28:0] rx_id0_i,
    input  wire logic [28:0] rx_id1_i,
    output logic [1:0]       rx_acc_o,
    output logic [1:0]       rx_acc_vld_o,
    // channel and system control
    output logic [1:0]       listen_only_o,
    output logic             module_reset_o,
    output logic             auto_reset_o
);
    ////////////////////////////////////////////////////////////////////////////
    cbc_state_t  state_ff;
    logic        rdy_ff;
    logic [10:0] rq_id_ff;
    logic [3:0]  rq_dlc_ff;
    logic        rq_rtr_ff;
    logic [63:0] rq_dat_ff;
    logic [15:0] tmo_ff;
    logic [1:0]  lsn_ff;
    logic [1:0]  open_ff;
    logic        mrst_pend_ff;
    logic [1:0]  cfg_sync_ff;
    logic        ctrl_en_ff;
    logic [3:0]  stat_ff;
    logic [3:0]  mask_ff;
    logic [7:0]  last_rc_ff;
    logic        take;
    logic        rsp_done;
    logic        ch_grp;
    logic        ch;
    logic [7:0]  sub;
    logic        is_data;
    cbc_ftype_t  ftype;
    logic        lo_used;
    logic        hi_used;
    logic [1:0]  flt_clr;
    logic [1:0]  flt_wr;
    logic [28:0] flt_lo;
    logic [28:0] flt_hi;
    logic [1:0]  flt_full;

    assign take     = req_valid_i & rdy_ff;
    assign req_ready_o = rdy_ff;
    assign rsp_done = resp_valid_o & resp_ready_i;
    assign ch_grp   = (rq_id_ff[10:8] == `CBC_CH1_GRP) | (rq_id_ff[10:8] == `CBC_CH2_GRP);
    assign ch       = (rq_id_ff[10:8] == `CBC_CH2_GRP);
    assign sub      = rq_id_ff[7:0];
    assign is_data  = ch_grp && sub >= `CBC_SUB_S11 && sub <= `CBC_SUB_G29;
    assign ftype    = cbc_ftype_t'(sub[1:0] - 2'h1);
    assign lo_used  = rq_dat_ff[31:0] != `CBC_UNUSED_WORD;
    assign hi_used  = rq_dat_ff[63:32] != `CBC_UNUSED_WORD;

    ////////////////////////////////////////////////////////////////////////////
    // strap pin crosses in through two flops before use
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_sync_ff <= 2'b00;
        end else begin
            cfg_sync_ff <= {cfg_sync_ff[0], cfg_mode_i};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // filter table writes; data outside a start/stop session is refused
    always_comb begin
        flt_clr = 2'b00;
        flt_wr  = 2'b00;
        flt_lo  = rq_dat_ff[28:0];
        flt_hi  = rq_dat_ff[60:32];
        if (state_ff == ST_EXEC && ch_grp && !rq_rtr_ff && rq_dlc_ff == `CBC_REQ_DLC) begin
            if (sub == `CBC_SUB_START || sub == `CBC_SUB_ALLPASS) flt_clr[ch] = 1'b1;
            if (is_data && open_ff[ch] && lo_used) begin
                if (!ftype[0]) begin
                    flt_wr[ch] = 1'b1;
                    flt_hi     = rq_dat_ff[28:0];
                end else if (hi_used && rq_dat_ff[31:0] < rq_dat_ff[63:32]) begin
                    flt_wr[ch] = 1'b1;
                end
            end
        end else if (state_ff == ST_WRHI) begin
            flt_wr[ch] = hi_used; // second single id of the same request
            flt_lo     = rq_dat_ff[60:32];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one table per channel
    cbc_filter u_flt0 (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .clear_i     (flt_clr[0]),
        .wr_i        (flt_wr[0]),
        .wr_type_i   (ftype),
        .wr_lo_i     (flt_lo),
        .wr_hi_i     (flt_hi),
        .full_o      (flt_full[0]),
        .chk_i       (rx_vld_i[0]),
        .chk_id_i    (rx_id0_i),
        .chk_ext_i   (rx_ext_i[0]),
        .match_o     (rx_acc_o[0]),
        .match_vld_o (rx_acc_vld_o[0])
    );
    cbc_filter u_flt1 (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .clear_i     (flt_clr[1]),
        .wr_i        (flt_wr[1]),
        .wr_type_i   (ftype),
        .wr_lo_i     (flt_lo),
        .wr_hi_i     (flt_hi),
        .full_o      (flt_full[1]),
        .chk_i       (rx_vld_i[1]),
        .chk_id_i    (rx_id1_i),
        .chk_ext_i   (rx_ext_i[1]),
        .match_o     (rx_acc_o[1]),
        .match_vld_o (rx_acc_vld_o[1])
    );

    ////////////////////////////////////////////////////////////////////////////
    // command sequencer: take, execute, answer, then accept again
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff     <= ST_IDLE;
            rdy_ff       <= 1'b0;
            rq_id_ff     <= 11'h000;
            rq_dlc_ff    <= 4'h0;
            rq_rtr_ff    <= 1'b0;
            rq_dat_ff    <= 64'h0;
            resp_valid_o <= 1'b0;
            resp_id_o    <= 11'h000;
            resp_dlc_o   <= 4'h0;
            resp_data_o  <= 64'h0;
            tmo_ff       <= 16'h0000;
            lsn_ff       <= 2'b00;
            open_ff      <= 2'b00;
            mrst_pend_ff <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    rdy_ff <= ctrl_en_ff & ~take;
                    if (take) begin
                        rq_id_ff  <= req_id_i;
                        rq_dlc_ff <= req_dlc_i;
                        rq_rtr_ff <= req_rtr_i;
                        rq_dat_ff <= req_data_i;
                        state_ff  <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    resp_id_o   <= rq_id_ff + `CBC_RSP_OFS;
                    resp_dlc_o  <= 4'h1;
                    resp_data_o <= 64'h0;
                    state_ff    <= ST_RESP;
                    if (rq_rtr_ff) begin
                        resp_data_o[7:0] <= `CBC_RC_RTR;
                    end else if (rq_dlc_ff != `CBC_REQ_DLC) begin
                        resp_data_o[7:0] <= `CBC_RC_LEN;
                    end else if (rq_id_ff == `CBC_CMD_FWVER) begin
                        resp_dlc_o        <= 4'h2;
                        resp_data_o[15:0] <= {`CBC_FW_INT, `CBC_FW_FRAC};
                    end else if (rq_id_ff == `CBC_CMD_MRESET) begin
                        if (cfg_sync_ff[1]) begin
                            mrst_pend_ff <= 1'b1;
                        end else begin
                            resp_data_o[7:0] <= `CBC_RC_PROC;
                        end
                    end else if (rq_id_ff == `CBC_CMD_SETTMO) begin
                        tmo_ff <= rq_dat_ff[15:0];
                    end else if (rq_id_ff == `CBC_CMD_GETTMO) begin
                        resp_dlc_o        <= 4'h2;
                        resp_data_o[15:0] <= tmo_ff;
                    end else if (rq_id_ff == `CBC_CMD_SETLSN) begin
                        if (rq_dat_ff[7:0] != 8'h01 && rq_dat_ff[7:0] != 8'h02) begin
                            resp_data_o[7:0] <= `CBC_RC_CHAN;
                        end else if (rq_dat_ff[15:9] != 7'h00) begin
                            resp_data_o[7:0] <= `CBC_RC_PARAM;
                        end else begin
                            lsn_ff[rq_dat_ff[1]] <= rq_dat_ff[8];
                        end
                    end else if (rq_id_ff == `CBC_CMD_GETLSN) begin
                        resp_dlc_o <= 4'h2;
                        if (rq_dat_ff[7:0] == 8'h01 || rq_dat_ff[7:0] == 8'h02) begin
                            resp_data_o[8] <= lsn_ff[rq_dat_ff[1]];
                        end else begin
                            resp_data_o[7:0] <= `CBC_RC_CHAN;
                        end
                    end else if (ch_grp && (sub == `CBC_SUB_START || sub == `CBC_SUB_ALLPASS)) begin
                        open_ff[ch] <= (sub == `CBC_SUB_START);
                    end else if (ch_grp && sub == `CBC_SUB_STOP) begin
                        open_ff[ch] <= 1'b0;
                    end else if (is_data) begin
                        if (!open_ff[ch]) begin
                            resp_data_o[7:0] <= `CBC_RC_PROC;
                        end else if (ftype[0] && lo_used != hi_used) begin
                            resp_data_o[7:0] <= `CBC_RC_PARAM;
                        end else if (ftype[0] && lo_used && rq_dat_ff[31:0] >= rq_dat_ff[63:32]) begin
                            resp_data_o[7:0] <= `CBC_RC_PARAM;
                        end else if ((lo_used || hi_used) && flt_full[ch]) begin
                            resp_data_o[7:0] <= `CBC_RC_FILT;
                        end else if (!ftype[0]) begin
                            state_ff <= ST_WRHI;
                        end
                    end else begin
                        resp_data_o[7:0] <= `CBC_RC_CMD;
                    end
                end
                ST_WRHI: begin
                    state_ff <= ST_RESP;
                    if (hi_used && flt_full[ch]) resp_data_o[7:0] <= `CBC_RC_FILT;
                end
                ST_RESP: begin
                    resp_valid_o <= ~rsp_done;
                    if (rsp_done) begin
                        state_ff     <= ST_IDLE;
                        rdy_ff       <= ctrl_en_ff;
                        mrst_pend_ff <= 1'b0;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // module reset leaves only after its answer is on the wire
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            module_reset_o <= 1'b0;
            listen_only_o  <= 2'b00;
        end else begin
            module_reset_o <= rsp_done & mrst_pend_ff;
            listen_only_o  <= lsn_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus-off persistence timer; any gap in bus-off restarts the count
    logic [31:0] tick_cnt_ff;
    logic [15:0] bo_sec_ff;
    logic        bus_off;

    assign bus_off = |bus_off_i;

    always_ff @(posedge clk_i) begin
        if (rst_i || !bus_off) begin
            tick_cnt_ff  <= 32'h0;
            bo_sec_ff    <= 16'h0000;
            auto_reset_o <= 1'b0;
        end else begin
            auto_reset_o <= 1'b0;
            if (tick_cnt_ff == 32'(TICK_CYC - 1)) begin
                tick_cnt_ff <= 32'h0;
                bo_sec_ff   <= bo_sec_ff + 16'h0001;
                if (tmo_ff != 16'h0000 && bo_sec_ff + 16'h0001 == tmo_ff) begin
                    auto_reset_o <= 1'b1;
                    bo_sec_ff    <= 16'h0000;
                end
            end else begin
                tick_cnt_ff <= tick_cnt_ff + 32'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // wishbone slave: one wait state, unmapped reads return zero
    logic [3:0] stat_set;
    logic       wb_wr;

    assign wb_wr = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
    assign stat_set = {rsp_done & (resp_data_o[7:0] != 8'h00) & (resp_dlc_o == 4'h1),
                       auto_reset_o, rsp_done & mrst_pend_ff, rsp_done};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0;
        end else begin
            ack_o <= cyc_i & stb_i & ~ack_o;
            case (adr_i)
                `CBC_OFS_STAT: dat_o <= {28'h0, stat_ff};
                `CBC_OFS_MASK: dat_o <= {28'h0, mask_ff};
                `CBC_OFS_CTRL: dat_o <= {31'h0, ctrl_en_ff};
                `CBC_OFS_INFO: dat_o <= {tmo_ff, last_rc_ff, 3'h0, cfg_sync_ff[1], open_ff, lsn_ff};
                default:       dat_o <= 32'h0;
            endcase
        end
    end

    // sticky events: a new event wins over a write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_ff <= 4'h0;
            irq_o   <= 1'b0;
        end else begin
            stat_ff <= (stat_ff & ~((wb_wr && adr_i == `CBC_OFS_STAT) ? dat_i[3:0] : 4'h0))
                       | stat_set;
            irq_o   <= |(stat_ff & mask_ff);
        end
    end

    // mask, enable and last result code
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_ff    <= 4'h0;
            ctrl_en_ff <= `CBC_CTRL_RST;
            last_rc_ff <= 8'h00;
        end else begin
            if (wb_wr && adr_i == `CBC_OFS_MASK) mask_ff <= dat_i[3:0];
            if (wb_wr && adr_i == `CBC_OFS_CTRL) ctrl_en_ff <= dat_i[0];
            if (rsp_done) last_rc_ff <= resp_data_o[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_rsp_id;
        @(posedge clk_i) disable iff (rst_i)
        resp_valid_o |-> resp_id_o == rq_id_ff + `CBC_RSP_OFS;
    endproperty
    a_rsp_id: assert property (p_rsp_id) else $error("response id offset wrong");

    property p_fw;
        @(posedge clk_i) disable iff (rst_i)
        (take && req_id_i == `CBC_CMD_FWVER && req_dlc_i == `CBC_REQ_DLC && !req_rtr_i)
        |-> ##3 resp_valid_o && resp_dlc_o == 4'h2
            && resp_data_o[15:0] == {`CBC_FW_INT, `CBC_FW_FRAC};
    endproperty
    a_fw: assert property (p_fw) else $error("version reply malformed");

    property p_mrst_len;
        @(posedge clk_i) disable iff (rst_i)
        (resp_valid_o && rq_id_ff == `CBC_CMD_MRESET) |-> resp_dlc_o == 4'h1;
    endproperty
    a_mrst_len: assert property (p_mrst_len) else $error("reset reply not one byte");

    property p_settmo;
        @(posedge clk_i) disable iff (rst_i)
        (take && req_id_i == `CBC_CMD_SETTMO && req_dlc_i == `CBC_REQ_DLC && !req_rtr_i)
        |-> ##2 tmo_ff == $past(req_data_i[15:0], 2) && resp_dlc_o == 4'h1;
    endproperty
    a_settmo: assert property (p_settmo) else $error("time not stored");

    property p_gettmo;
        @(posedge clk_i) disable iff (rst_i)
        (resp_valid_o && rq_id_ff == `CBC_CMD_GETTMO && rq_dlc_ff == `CBC_REQ_DLC && !rq_rtr_ff)
        |-> resp_data_o[15:0] == tmo_ff && resp_dlc_o == 4'h2;
    endproperty
    a_gettmo: assert property (p_gettmo) else $error("time readback wrong");

    property p_auto;
        @(posedge clk_i) disable iff (rst_i)
        auto_reset_o |-> tmo_ff != 16'h0000 && $past(bus_off) && bo_sec_ff == 16'h0000;
    endproperty
    a_auto: assert property (p_auto) else $error("auto reset without cause");

    property p_mrst_cfg;
        @(posedge clk_i) disable iff (rst_i)
        module_reset_o |-> $past(mrst_pend_ff) && $past(rsp_done);
    endproperty
    a_mrst_cfg: assert property (p_mrst_cfg) else $error("reset outside config mode");

    property p_one_at_a_time;
        @(posedge clk_i) disable iff (rst_i)
        (state_ff != ST_IDLE) |-> !rdy_ff;
    endproperty
    a_one_at_a_time: assert property (p_one_at_a_time) else $error("request taken while busy");

    property p_rc_range;
        @(posedge clk_i) disable iff (rst_i)
        (resp_valid_o && resp_dlc_o == 4'h1) |-> resp_data_o[7:0] <= `CBC_RC_RTR;
    endproperty
    a_rc_range: assert property (p_rc_range) else $error("result code out of range");

    c_fw_reply:  cover property (@(posedge clk_i) disable iff (rst_i)
        rsp_done && rq_id_ff == `CBC_CMD_FWVER);
    c_auto_rst:  cover property (@(posedge clk_i) disable iff (rst_i) auto_reset_o);
    c_flt_write: cover property (@(posedge clk_i) disable iff (rst_i) |flt_wr);
endmodule // cbc_top

/* File: testbench/cbc_host.sv */
// host model issuing configuration request frames
`timescale 1ns/1ps
module cbc_host (
    // clock
    input  wire logic   clk_i,
    // request and response handshake
    output logic        req_valid_o,
    output logic [10:0] req_id_o,
    output logic [3:0]  req_dlc_o,
    output logic        req_rtr_o,
    output logic [63:0] req_data_o,
    input  wire logic   req_ready_i,
    output logic        resp_ready_o
);
    logic [1:0] n = 2'h0;
    logic       tmo = 1'b0;
    initial {req_valid_o, req_id_o, req_dlc_o, req_rtr_o, req_data_o, resp_ready_o} = '0;
    // stall one slot in four, so responses meet a slow host too
    always @(posedge clk_i) begin
        n <= n + 2'h1;
        resp_ready_o <= n != 2'h3;
    end
    // frame level only, bit rate abstracted
    task automatic send(input logic [10:0] i, input logic [63:0] d, input logic [3:0] l,
                        input logic r);
        int k = 0;
        @(posedge clk_i);
        {req_valid_o, req_id_o, req_dlc_o, req_rtr_o, req_data_o} <= {1'b1, i, l, r, d};
        do @(posedge clk_i); while (req_ready_i !== 1'b1 && ++k < 400);
        {req_valid_o, req_data_o} <= {1'b0, ~d}; // stale bytes must never match
        tmo |= k >= 400;
    endtask
endmodule // cbc_host

/* File: testbench/tb_can_bridge_config_commands.sv */
// self-checking bench of the configuration command interpreter
`timescale 1ns/1ps
`include "cbc_regs.svh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin err_count++; \
$display("unexpected %s exp %h got %h", n, e, s); end end
module tb_can_bridge_config_commands;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic        cfg_mode_i = 1'b1, ack_o, irq_o, req_valid_i, req_rtr_i, req_ready_o;
    logic        resp_valid_o, resp_ready_i, module_reset_o, auto_reset_o;
    logic [3:0]  adr_i = 4'h0, req_dlc_i, resp_dlc_o;
    logic [31:0] dat_i = 32'h0, dat_o, rd, seed = 32'd59;
    logic [10:0] req_id_i, resp_id_o, fid;
    logic [63:0] req_data_i, resp_data_o;
    logic [1:0]  bus_off_i = 2'h0, rx_vld_i = 2'h0, rx_acc_o, rx_acc_vld_o, listen_only_o;
    logic [28:0] rx_id0_i = 29'h0;
    logic [78:0] ex, q[$];
    int          err_count = 0, total_checks = 0;
    cbc_top #(.TICK_CYC(10)) u_cbc_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i(4'hf), .dat_i, .dat_o, .ack_o, .irq_o, .req_valid_i, .req_id_i, .req_dlc_i,
        .req_rtr_i, .req_data_i, .req_ready_o, .resp_valid_o, .resp_id_o, .resp_dlc_o,
        .resp_data_o, .resp_ready_i, .cfg_mode_i, .bus_off_i, .rx_vld_i, .rx_ext_i(2'h0),
        .rx_id0_i, .rx_id1_i(29'h0), .rx_acc_o, .rx_acc_vld_o, .listen_only_o,
        .module_reset_o, .auto_reset_o);
    cbc_host u_cbc_host (.clk_i, .req_valid_o(req_valid_i), .req_id_o(req_id_i),
        .req_dlc_o(req_dlc_i), .req_rtr_o(req_rtr_i), .req_data_o(req_data_i),
        .req_ready_i(req_ready_o), .resp_ready_o(resp_ready_i));
    initial forever #20 clk_i = ~clk_i;
    // each accepted response meets the oldest note
    always @(posedge clk_i) if (resp_valid_o === 1'b1 && resp_ready_i === 1'b1) begin
        ex = q.size() ? q.pop_front() : 79'h0;
        `CHK("response", ex, {resp_id_o, resp_dlc_o, resp_data_o})
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic rq(input logic [10:0] i, input logic [63:0] d, input logic [3:0] c,
                      input logic [63:0] e, input logic [3:0] l = 4'h8, input logic r = 1'b0);
        q.push_back({i + `CBC_RSP_OFS, c, e});
        u_cbc_host.send(i, d, l, r);
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k = 0;
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, d};
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++k < 50);
        if (k >= 50) begin
            err_count++;
            stop_test();
        end
        rd = dat_o;
        {cyc_i, stb_i} <= 2'h0;
        @(posedge clk_i);
    endtask
    task automatic scr(input logic [10:0] id, input logic e);
        {rx_vld_i, rx_id0_i} <= {2'h1, 18'h0, id};
        @(posedge clk_i);
        {rx_vld_i, rx_id0_i} <= {2'h0, ~rx_id0_i};
        @(posedge clk_i);
        `CHK("accept", {1'b1, e}, {rx_acc_vld_o[0], rx_acc_o[0]})
    endtask
    task automatic hit(ref logic s, input int lo);
        int k = 0;
        do @(posedge clk_i); while (s !== 1'b1 && ++k < 60);
        `CHK("pulse", 1'b1, k >= lo && k < lo + 12)
    endtask
    task automatic drain();
        int k = 0;
        while (q.size() != 0 && k++ < 300) @(posedge clk_i);
        `CHK("drain", 0, q.size())
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rq(11'h001, 64'h0, 4'h2, {48'h0, `CBC_FW_INT, `CBC_FW_FRAC});
        rq(11'h003, 64'h2, 4'h1, 64'h0);
        rq(11'h004, 64'h0, 4'h2, 64'h2);
        rq(11'h001, 64'h0, 4'h1, 64'h7, 4'h8, 1'b1);
        rq(11'h001, 64'h0, 4'h1, 64'h6, 4'h4);
        rq(11'h00f, 64'h0, 4'h1, 64'h4);
        rq(11'h005, 64'h3, 4'h1, 64'h5);
        rq(11'h005, 64'h101, 4'h1, 64'h0);
        rq(11'h006, 64'h1, 4'h2, 64'h100);
        fid = 11'(xs());
        rq(11'h101, 64'h0, 4'h1, 64'h0);
        rq(11'h111, {32'hffffffff, 21'h0, fid}, 4'h1, 64'h0);
        rq(11'h112, {32'h10, 32'h20}, 4'h1, 64'h2);
        rq(11'h102, 64'h0, 4'h1, 64'h0);
        drain();
        scr(fid, 1'b1);
        scr(~fid, 1'b0);
        rq(11'h104, 64'h0, 4'h1, 64'h0);
        drain();
        scr(~fid, 1'b1);
        `CHK("listen", 2'h1, listen_only_o)
        $display("test commands done");
        wb(1'b1, `CBC_OFS_MASK, 32'h1);
        `CHK("irq", 1'b1, irq_o)
        wb(1'b1, `CBC_OFS_STAT, 32'h1);
        `CHK("irq", 1'b0, irq_o)
        wb(1'b0, 4'h2, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        rq(11'h002, 64'h0, 4'h1, 64'h0);
        hit(module_reset_o, 0);
        cfg_mode_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rq(11'h002, 64'h0, 4'h1, 64'h1);
        drain();
        bus_off_i <= 2'h1;
        hit(auto_reset_o, 18);
        `CHK("host", 1'b0, u_cbc_host.tmo)
        $display("test resets done");
        stop_test();
    end
endmodule // tb_can_bridge_config_commands
